/* File: common/sigu_map.vh */
// Register map, field positions and reset values of the status and pin unit.
// Assumes a 32-bit classic bus slave with one register per aligned word.
`ifndef SIGU_MAP_VH
`define SIGU_MAP_VH

// Register indices; byte address is four times the index
`define SIGU_IDX_IRQ_MODE 8'h28
`define SIGU_IDX_EVENT_MASK 8'h29
`define SIGU_IDX_EVENT_FLAGS 8'h2A
`define SIGU_IDX_CLIP_FLAGS 8'h2B
`define SIGU_IDX_PIN_DIR 8'h2C
`define SIGU_IDX_PIN_POL 8'h2D
`define SIGU_IDX_PIN_SENSE 8'h2E
`define SIGU_IDX_PIN_STATE 8'h2F
`define SIGU_IDX_PIN_MASK 8'h30

// Event flag and mode field positions
`define SIGU_EV_LOST 7
`define SIGU_EV_LOCKED 6
`define SIGU_EV_RISE 5
`define SIGU_EV_FALL 4
`define SIGU_EV_MUTE 3
`define SIGU_EV_CLIP 2
`define SIGU_EV_PIN 1
`define SIGU_MODE_DRV_HI 7
`define SIGU_MODE_DRV_LO 6
`define SIGU_MODE_CLIP_SENSE 0

// Interrupt drive codes
`define SIGU_DRV_HIGH 2'h0
`define SIGU_DRV_LOW 2'h1
`define SIGU_DRV_OD 2'h2

// Reset values
`define SIGU_RST_PIN_DIR 7'h00
`define SIGU_RST_PIN_POL 7'h7F
`define SIGU_RST_PIN_SENSE 7'h00
`define SIGU_RST_PIN_OUT 7'h00
`define SIGU_RST_PIN_MASK 4'h0
`define SIGU_RST_DRV 2'h0
`define SIGU_RST_EVENT_MASK 6'h00

// Sizes
`define SIGU_NUM_PINS 7
`define SIGU_NUM_MASKED 4
`define SIGU_NUM_CLIP 6

`endif

/* File: rtl/sigu_pin.v */
// One general-purpose pin: synchroniser, state capture and output drive.
// Assumes the pin input is asynchronous; all controls come from clk_i logic.
`timescale 1ns/1ps
`default_nettype none

module sigu_pin (
	// Clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Pad
	input wire pin_i,
	output reg pin_o,
	output reg pin_oe_o,
	// Configuration
	input wire pin_direction_bit_i,
	input wire pin_polarity_type_bit_i,
	input wire pin_sense_bit_i,
	input wire out_value_i,
	// State access
	input wire state_read_i,
	output wire pin_state_bit_o
);

	reg sync_meta;
	reg sync_pin;
	reg prev_active;
	reg edge_hit;
	wire active;

	assign active = pin_polarity_type_bit_i ? sync_pin : ~sync_pin;

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync_meta <= 1'b0;
			sync_pin <= 1'b0;
			prev_active <= 1'b0;
		end else if (ce_i) begin
			sync_meta <= pin_i;
			sync_pin <= sync_meta;
			prev_active <= active;
		end
	end

	// Capture ignores the mask entirely
	always @(posedge clk_i) begin
		if (rst_i) begin
			edge_hit <= 1'b0;
		end else if (ce_i) begin
			if (pin_direction_bit_i | ~pin_sense_bit_i) begin
				edge_hit <= 1'b0;
			end else if (active & ~prev_active) begin
				edge_hit <= 1'b1;
			end else if (state_read_i) begin
				edge_hit <= 1'b0;
			end
		end
	end

	// Level inputs report the active level so the summary tracks it
	assign pin_state_bit_o = pin_direction_bit_i ? out_value_i :
		(pin_sense_bit_i ? edge_hit : active);

	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else if (ce_i) begin
			if (!pin_direction_bit_i) begin
				pin_o <= 1'b0;
				pin_oe_o <= 1'b0;
			end else if (pin_polarity_type_bit_i) begin
				pin_o <= 1'b0;
				pin_oe_o <= ~out_value_i;
			end else begin
				pin_o <= out_value_i;
				pin_oe_o <= 1'b1;
			end
		end
	end

endmodule // sigu_pin

`default_nettype wire

/* File: rtl/sigu_top.v */
// Event flags, channel clip flags and seven general-purpose pins behind a
// classic bus slave, with one configurable interrupt output.
// Assumes event and clip inputs are one-cycle pulses from clk_i logic.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sigu_map.vh"

module sigu_top #(
	parameter NUM_PINS = `SIGU_NUM_PINS,
	parameter NUM_MASKED = `SIGU_NUM_MASKED,
	parameter NUM_CLIP = `SIGU_NUM_CLIP
) (
	// Clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,

	// Register bus
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [9:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,

	// Converter and volume engine events
	input wire converter_lock_evt_i,
	input wire converter_lost_evt_i,
	input wire ramp_rise_done_evt_i,
	input wire ramp_fall_done_evt_i,
	input wire mute_done_evt_i,

	// Per-channel clip pulses, A1 B1 A2 B2 A3 B3
	input wire [NUM_CLIP-1:0] channel_clip_i,

	// General-purpose pins
	input wire [NUM_PINS-1:0] pin_i,
	output wire [NUM_PINS-1:0] pin_o,
	output wire [NUM_PINS-1:0] pin_oe_o,

	// Interrupt pin
	output reg irq_o,
	output reg irq_oe_o
);

	// Bus decode
	wire [7:0] reg_index;
	wire bus_request;
	wire bus_write;
	wire bus_read;
	wire hit_irq_mode;
	wire hit_event_mask;
	wire hit_event_flags;
	wire hit_clip_flags;
	wire hit_pin_dir;
	wire hit_pin_pol;
	wire hit_pin_sense;
	wire hit_pin_state;
	wire hit_pin_mask;

	// Control registers
	reg [1:0] irq_drive_mode;
	reg clip_sense_select;
	reg [5:0] event_mask;
	reg [NUM_PINS-1:0] pin_direction;
	reg [NUM_PINS-1:0] pin_polarity_type;
	reg [NUM_PINS-1:0] pin_sense_select;
	reg [NUM_PINS-1:0] pin_out_value;
	reg [NUM_MASKED-1:0] pin_event_mask;

	// Event state
	reg converter_locked_flag;
	reg converter_lost_flag;
	reg ramp_rise_done_flag;
	reg ramp_fall_done_flag;
	reg mute_done_flag;
	reg [NUM_CLIP-1:0] channel_clip_bit;

	// Derived
	wire clip_summary_flag;
	wire pin_summary_flag;
	wire [NUM_PINS-1:0] pin_state_bit;
	wire read_events;
	wire read_clips;
	wire read_pins;
	wire clip_clear;
	wire [5:0] event_vector;
	wire irq_active;
	reg [7:0] next_rdata;

	assign reg_index = adr_i[9:2];

	// A request is taken in the cycle before ack rises
	assign bus_request = cyc_i & stb_i & ~ack_o & ce_i;
	assign bus_write = bus_request & we_i & sel_i[0];
	assign bus_read = bus_request & ~we_i;

	assign hit_irq_mode = (reg_index == `SIGU_IDX_IRQ_MODE);
	assign hit_event_mask = (reg_index == `SIGU_IDX_EVENT_MASK);
	assign hit_event_flags = (reg_index == `SIGU_IDX_EVENT_FLAGS);
	assign hit_clip_flags = (reg_index == `SIGU_IDX_CLIP_FLAGS);
	assign hit_pin_dir = (reg_index == `SIGU_IDX_PIN_DIR);
	assign hit_pin_pol = (reg_index == `SIGU_IDX_PIN_POL);
	assign hit_pin_sense = (reg_index == `SIGU_IDX_PIN_SENSE);
	assign hit_pin_state = (reg_index == `SIGU_IDX_PIN_STATE);
	assign hit_pin_mask = (reg_index == `SIGU_IDX_PIN_MASK);

	assign read_events = bus_read & hit_event_flags;
	assign read_clips = bus_read & hit_clip_flags;
	assign read_pins = bus_read & hit_pin_state;

	// Bus handshake: one wait-free cycle, ack drops the cycle after
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else if (ce_i) begin
			ack_o <= bus_request;
			if (bus_read) begin
				dat_o <= {24'h000000, next_rdata};
			end
		end
	end

	// Read data; unmapped words and reserved bits read as zero
	always @* begin
		next_rdata = 8'h00;
		if (hit_irq_mode) begin
			next_rdata[`SIGU_MODE_DRV_HI:`SIGU_MODE_DRV_LO] = irq_drive_mode;
			next_rdata[`SIGU_MODE_CLIP_SENSE] = clip_sense_select;
		end else if (hit_event_mask) begin
			next_rdata[7:2] = event_mask;
		end else if (hit_event_flags) begin
			next_rdata[7:1] = {event_vector, pin_summary_flag};
		end else if (hit_clip_flags) begin
			next_rdata[NUM_CLIP-1:0] = channel_clip_bit;
		end else if (hit_pin_dir) begin
			next_rdata[NUM_PINS-1:0] = pin_direction;
		end else if (hit_pin_pol) begin
			next_rdata[NUM_PINS-1:0] = pin_polarity_type;
		end else if (hit_pin_sense) begin
			next_rdata[NUM_PINS-1:0] = pin_sense_select;
		end else if (hit_pin_state) begin
			next_rdata[NUM_PINS-1:0] = pin_state_bit;
		end else if (hit_pin_mask) begin
			next_rdata[NUM_MASKED-1:0] = pin_event_mask;
		end
	end

	// Interrupt mode and event mask
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_drive_mode <= `SIGU_RST_DRV;
			clip_sense_select <= 1'b0;
			event_mask <= `SIGU_RST_EVENT_MASK;
		end else if (bus_write) begin
			if (hit_irq_mode) begin
				irq_drive_mode <= dat_i[`SIGU_MODE_DRV_HI:`SIGU_MODE_DRV_LO];
				clip_sense_select <= dat_i[`SIGU_MODE_CLIP_SENSE];
			end
			if (hit_event_mask) begin
				event_mask <= dat_i[7:2];
			end
		end
	end

	// Pin configuration registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_direction <= `SIGU_RST_PIN_DIR;
			pin_polarity_type <= `SIGU_RST_PIN_POL;
			pin_sense_select <= `SIGU_RST_PIN_SENSE;
			pin_out_value <= `SIGU_RST_PIN_OUT;
			pin_event_mask <= `SIGU_RST_PIN_MASK;
		end else if (bus_write) begin
			if (hit_pin_dir) begin
				pin_direction <= dat_i[NUM_PINS-1:0];
			end
			if (hit_pin_pol) begin
				pin_polarity_type <= dat_i[NUM_PINS-1:0];
			end
			if (hit_pin_sense) begin
				pin_sense_select <= dat_i[NUM_PINS-1:0];
			end
			if (hit_pin_state) begin
				pin_out_value <= dat_i[NUM_PINS-1:0];
			end
			if (hit_pin_mask) begin
				pin_event_mask <= dat_i[NUM_MASKED-1:0];
			end
		end
	end

	// Converter state: only the latest of lock and loss survives.
	// A loss in the same cycle as a lock wins, the safer report.
	always @(posedge clk_i) begin
		if (rst_i) begin
			converter_locked_flag <= 1'b0;
			converter_lost_flag <= 1'b0;
		end else if (ce_i) begin
			if (converter_lost_evt_i) begin
				converter_lost_flag <= 1'b1;
				converter_locked_flag <= 1'b0;
			end else if (converter_lock_evt_i) begin
				converter_locked_flag <= 1'b1;
				converter_lost_flag <= 1'b0;
			end else if (read_events) begin
				converter_locked_flag <= 1'b0;
				converter_lost_flag <= 1'b0;
			end
		end
	end

	// Completion flags; an event in the reading cycle is kept
	always @(posedge clk_i) begin
		if (rst_i) begin
			ramp_rise_done_flag <= 1'b0;
			ramp_fall_done_flag <= 1'b0;
			mute_done_flag <= 1'b0;
		end else if (ce_i) begin
			if (ramp_rise_done_evt_i) begin
				ramp_rise_done_flag <= 1'b1;
			end else if (read_events) begin
				ramp_rise_done_flag <= 1'b0;
			end
			if (ramp_fall_done_evt_i) begin
				ramp_fall_done_flag <= 1'b1;
			end else if (read_events) begin
				ramp_fall_done_flag <= 1'b0;
			end
			if (mute_done_evt_i) begin
				mute_done_flag <= 1'b1;
			end else if (read_events) begin
				mute_done_flag <= 1'b0;
			end
		end
	end

	// Clip bits never look at the clip mask, so polling works
	assign clip_clear = read_clips & clip_sense_select;

	always @(posedge clk_i) begin
		if (rst_i) begin
			channel_clip_bit <= {NUM_CLIP{1'b0}};
		end else if (ce_i) begin
			channel_clip_bit <= channel_clip_i | (channel_clip_bit & ~{NUM_CLIP{clip_clear}});
		end
	end

	assign clip_summary_flag = |channel_clip_bit;

	// Only input pins with a mask bit feed the summary
	assign pin_summary_flag = |(pin_state_bit[NUM_MASKED-1:0] & pin_event_mask
		& ~pin_direction[NUM_MASKED-1:0]);

	assign event_vector = {converter_lost_flag, converter_locked_flag, ramp_rise_done_flag,
		ramp_fall_done_flag, mute_done_flag, clip_summary_flag};

	// Pin summary is gated by the pin masks, not the event mask
	assign irq_active = (|(event_vector & event_mask)) | pin_summary_flag;

	// Interrupt pin drive
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			irq_oe_o <= 1'b1;
		end else if (ce_i) begin
			case (irq_drive_mode)
				`SIGU_DRV_HIGH: begin
					irq_o <= irq_active;
					irq_oe_o <= 1'b1;
				end
				`SIGU_DRV_LOW: begin
					irq_o <= ~irq_active;
					irq_oe_o <= 1'b1;
				end
				`SIGU_DRV_OD: begin
					irq_o <= 1'b0;
					irq_oe_o <= irq_active;
				end
				default: begin
					// Reserved code: pin released, nothing signalled
					irq_o <= 1'b0;
					irq_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// One pin slice per pin; the event flag read does not reach them
	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p = p + 1) begin : g_pin
			sigu_pin u_pin (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.pin_i(pin_i[p]),
				.pin_o(pin_o[p]),
				.pin_oe_o(pin_oe_o[p]),
				.pin_direction_bit_i(pin_direction[p]),
				.pin_polarity_type_bit_i(pin_polarity_type[p]),
				.pin_sense_bit_i(pin_sense_select[p]),
				.out_value_i(pin_out_value[p]),
				.state_read_i(read_pins),
				.pin_state_bit_o(pin_state_bit[p])
			);
		end
	endgenerate

endmodule // sigu_top

`default_nettype wire

/* File: tb/sigu_monitor.sv */
// Port assertions for the status and pin unit, bound into sigu_top.
// Assumes ce_i stays high; drive controls are shadowed from bus writes.
`timescale 1ns/1ps
`default_nettype none
`include "sigu_map.vh"

module sigu_monitor #(
	parameter NUM_PINS = 7
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Pads
	input wire logic [NUM_PINS-1:0] pin_o,
	input wire logic [NUM_PINS-1:0] pin_oe_o,
	input wire logic irq_o,
	input wire logic irq_oe_o
);
	logic [NUM_PINS-1:0] dir;
	logic [NUM_PINS-1:0] pol;
	logic [NUM_PINS-1:0] outv;
	logic [1:0] mode;
	wire take = cyc_i && stb_i && ce_i && !ack_o;
	wire [NUM_PINS-1:0] exp_oe = dir & (~pol | ~outv);
	wire [NUM_PINS-1:0] exp_pin = dir & ~pol & outv;

	// Shadows change on the taking edge, as the unit's registers do
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir <= '0;
			pol <= '1;
			outv <= '0;
			mode <= `SIGU_RST_DRV;
		end else if (take && we_i && sel_i[0]) begin
			case (adr_i[9:2])
				`SIGU_IDX_PIN_DIR: dir <= dat_i[NUM_PINS-1:0];
				`SIGU_IDX_PIN_POL: pol <= dat_i[NUM_PINS-1:0];
				`SIGU_IDX_PIN_STATE: outv <= dat_i[NUM_PINS-1:0];
				`SIGU_IDX_IRQ_MODE: mode <= dat_i[7:6];
				default: ;
			endcase
		end
	end

	chk_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> ack_o) else $error("request not answered next cycle");
	chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack longer than one cycle");
	chk_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
	chk_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && !we_i |-> dat_o[31:8] == 24'h000000) else $error("read data upper bits set");
	chk_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> (pin_o & pin_oe_o) == $past(exp_pin)) else $error("pin level wrong");
	chk_pin_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> pin_oe_o == $past(exp_oe)) else $error("pin enable wrong");
	chk_irq_push: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $past(mode) < 2'h2 |-> irq_oe_o) else $error("irq not driven");
	chk_irq_drain: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $past(mode) == `SIGU_DRV_OD |-> !irq_o) else $error("irq drives high");
	chk_irq_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $past(mode) == 2'h3 |-> !irq_o && !irq_oe_o) else $error("irq not released");
endmodule // sigu_monitor

bind sigu_top sigu_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i,
	.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pin_o, .pin_oe_o, .irq_o, .irq_oe_o);

`default_nettype wire

/* File: tb/sigu_pads.sv */
// Far side of the unit: external pin drivers and pull-ups.
// Assumes the bench never drives a pad the unit drives.
`timescale 1ns/1ps
`default_nettype none

module sigu_pads (
	// Unit side
	input wire logic [6:0] pin_o,
	input wire logic [6:0] pin_oe_o,
	input wire logic irq_o,
	input wire logic irq_oe_o,
	// External drivers
	input wire logic [6:0] ext_val,
	input wire logic [6:0] ext_en,
	// Resolved levels
	output logic [6:0] pin_lvl,
	output logic irq_lvl
);
	// Pads that neither side drives read high, never the last value
	always_comb begin
		for (int k = 0; k < 7; k++) begin
			pin_lvl[k] = pin_oe_o[k] ? pin_o[k] : (ext_en[k] ? ext_val[k] : 1'b1);
		end
		irq_lvl = irq_oe_o ? irq_o : 1'b1;
	end
endmodule // sigu_pads

`default_nettype wire

/* File: tb/status_interrupt_gpio_unit_test.sv */
// Self-checking bench for the status and pin unit.
// Assumes sigu_top and sigu_pads; ce_i and sel_i active outside the freeze case.
`timescale 1ns/1ps
`default_nettype none
`include "sigu_map.vh"

module status_interrupt_gpio_unit_test;
	localparam logic [7:0] r_flag = `SIGU_IDX_EVENT_FLAGS;
	localparam logic [7:0] r_st = `SIGU_IDX_PIN_STATE;
	localparam logic [7:0] r_mode = `SIGU_IDX_IRQ_MODE;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [3:0] sel_i = 4'hF;
	logic [3:0] lane = 4'hF;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [9:0] adr_i = 10'h000;
	logic [31:0] dat_i = 32'h00000000;
	logic [4:0] ev = 5'h00;
	logic [5:0] channel_clip_i = 6'h00;
	logic [6:0] ext_val = 7'h00;
	logic [6:0] ext_en = 7'h7F;
	logic [7:0] q;
	wire [31:0] dat_o;
	wire ack_o, irq_o, irq_oe_o, irq_lvl;
	wire [6:0] pin_i, pin_o, pin_oe_o;
	int n_fail = 0;
	int cmp_count = 0;
	int ticks = 0;

	sigu_top uut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .converter_lock_evt_i(ev[0]), .converter_lost_evt_i(ev[1]),
		.ramp_rise_done_evt_i(ev[2]), .ramp_fall_done_evt_i(ev[3]), .mute_done_evt_i(ev[4]),
		.channel_clip_i, .pin_i, .pin_o, .pin_oe_o, .irq_o, .irq_oe_o);
	sigu_pads pads (.pin_o, .pin_oe_o, .irq_o, .irq_oe_o, .ext_val, .ext_en, .pin_lvl(pin_i), .irq_lvl);

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 3000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle; waits for ack, then idles a cycle so strobes never merge
	task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= lane;
		adr_i <= {i, 2'b00};
		dat_i <= {24'h000000, d};
		// Ends on ack; without one only the bench timeout ends this wait
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1);
		// Answer comes one cycle after the taking edge
		chk(n[7:0], 8'h02);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		wb(1'b0, i, 8'h00);
		chk(q, e);
	endtask

	task automatic fire(input logic [4:0] e, input logic [5:0] c);
		ev <= e;
		channel_clip_i <= c;
		@(posedge clk_i);
		ev <= 5'h00;
		channel_clip_i <= 6'h00;
		@(posedge clk_i);
	endtask

	task automatic t_reset();
		rd(`SIGU_IDX_PIN_DIR, 8'h00);
		rd(`SIGU_IDX_PIN_POL, 8'h7F);
		rd(`SIGU_IDX_PIN_SENSE, 8'h00);
		rd(r_flag, 8'h00);
		rd(`SIGU_IDX_CLIP_FLAGS, 8'h00);
		rd(8'h10, 8'h00);
		wb(1'b1, `SIGU_IDX_PIN_MASK, 8'hFF);
		rd(`SIGU_IDX_PIN_MASK, 8'h0F);
	endtask

	task automatic t_events();
		fire(5'h01, 6'h00);
		fire(5'h02, 6'h00);
		rd(r_flag, 8'h80);
		fire(5'h01, 6'h00);
		rd(r_flag, 8'h40);
		rd(r_flag, 8'h00);
		fire(5'h1C, 6'h00);
		rd(r_flag, 8'h38);
		rd(r_flag, 8'h00);
	endtask

	task automatic t_irq();
		wb(1'b1, `SIGU_IDX_EVENT_MASK, 8'h20);
		fire(5'h04, 6'h00);
		@(posedge clk_i);
		chk({7'h00, irq_lvl}, 8'h01);
		wb(1'b1, r_mode, 8'h40);
		chk({7'h00, irq_lvl}, 8'h00);
		wb(1'b1, r_mode, 8'h80);
		chk({7'h00, irq_lvl}, 8'h00);
		rd(r_flag, 8'h20);
		chk({7'h00, irq_lvl}, 8'h01);
		wb(1'b1, r_mode, 8'hC0);
		chk({7'h00, irq_lvl}, 8'h01);
		wb(1'b1, r_mode, 8'h00);
		wb(1'b1, `SIGU_IDX_EVENT_MASK, 8'h00);
	endtask

	task automatic t_clip();
		fire(5'h00, 6'h21);
		rd(r_flag, 8'h04);
		rd(`SIGU_IDX_CLIP_FLAGS, 8'h21);
		fire(5'h00, 6'h02);
		rd(`SIGU_IDX_CLIP_FLAGS, 8'h23);
		wb(1'b1, r_mode, 8'h01);
		rd(`SIGU_IDX_CLIP_FLAGS, 8'h23);
		rd(`SIGU_IDX_CLIP_FLAGS, 8'h00);
		rd(r_flag, 8'h00);
		wb(1'b1, r_mode, 8'h00);
	endtask

	// Frozen unit ignores events; a write without lane 0 stores nothing
	task automatic t_freeze();
		ce_i <= 1'b0;
		fire(5'h01, 6'h3F);
		ce_i <= 1'b1;
		rd(r_flag, 8'h00);
		rd(`SIGU_IDX_CLIP_FLAGS, 8'h00);
		lane = 4'hE;
		wb(1'b1, `SIGU_IDX_PIN_MASK, 8'h05);
		lane = 4'hF;
		rd(`SIGU_IDX_PIN_MASK, 8'h0F);
	endtask

	task automatic t_pins();
		wb(1'b1, `SIGU_IDX_PIN_MASK, 8'h01);
		ext_val <= 7'h01;
		repeat (3) @(posedge clk_i);
		rd(r_st, 8'h01);
		rd(r_flag, 8'h02);
		rd(r_flag, 8'h02);
		rd(r_st, 8'h01);
		ext_val <= 7'h04;
		wb(1'b1, `SIGU_IDX_PIN_SENSE, 8'h02);
		wb(1'b1, `SIGU_IDX_PIN_POL, 8'h7B);
		wb(1'b1, `SIGU_IDX_PIN_MASK, 8'h03);
		ext_val <= 7'h02;
		repeat (3) @(posedge clk_i);
		rd(r_flag, 8'h02);
		rd(r_st, 8'h06);
		rd(r_st, 8'h04);
		rd(r_flag, 8'h00);
		ext_val <= 7'h04;
		repeat (3) @(posedge clk_i);
		rd(r_st, 8'h00);
		wb(1'b1, `SIGU_IDX_PIN_MASK, 8'h00);
		wb(1'b1, `SIGU_IDX_PIN_SENSE, 8'h00);
	endtask

	task automatic t_out();
		ext_en <= 7'h7C;
		wb(1'b1, `SIGU_IDX_PIN_DIR, 8'h03);
		wb(1'b1, `SIGU_IDX_PIN_POL, 8'h7E);
		wb(1'b1, r_st, 8'h03);
		chk({6'h00, pin_i[1:0]}, 8'h03);
		wb(1'b1, r_st, 8'h00);
		chk({6'h00, pin_i[1:0]}, 8'h00);
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_events();
		t_irq();
		t_clip();
		t_freeze();
		t_pins();
		t_out();
		wrap_up();
	end
endmodule // status_interrupt_gpio_unit_test

`default_nettype wire
